// ---- hdl/ddstc_pkg.sv ----
// package for the dds tuning control core: widths, serial word layout, reset values
// assumes a single 10 MHz master clock domain
package ddstc_pkg;
    localparam int ACC_W = 28;
    localparam int PH_W = 12;
    localparam int WORD_W = 16;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] WORD_BITS = 5'h10;
    // serial word address field (top two bits)
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 14;
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_FREQ_A = 2'h1;
    localparam logic [1:0] ADDR_FREQ_B = 2'h2;
    localparam logic [1:0] ADDR_PHASE = 2'h3;
    // control word: which half of a tuning word is written
    localparam int CTL_HALF_HI = 11;
    // phase word: bit 12 selects offset b
    localparam int PH_SEL_BIT = 12;
    // control word field positions
    localparam int CTL_FREQ_REG_CHOICE_BIT = 10;
    localparam int CTL_PSEL = 9;
    localparam int CTL_PINSW = 8;
    localparam int CTL_OUTEN = 5;
    localparam int CTL_DACPD = 6;
    localparam int CTL_SRC = 4;
    localparam logic [WORD_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [ACC_W-1:0] FREQ_RST = 28'h0000000;
    localparam logic [PH_W-1:0] PHASE_RST = 12'h000;
    localparam int HALF_W = 14;
endpackage

// ---- hdl/ddstc_sync2.sv ----
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module ddstc_sync2 (
    input wire logic clk,
    input wire logic rst,
    input wire logic pinIn,
    output logic pinSync
);
    logic stage1_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_q <= 1'b0;
            pinSync <= 1'b0;
        end else begin
            stage1_q <= pinIn;
            pinSync <= stage1_q;
        end
    end
endmodule

// ---- hdl/ddstc_core.sv ----
// digital control core: serial word load, tuning/phase registers, accumulator, logic out
// assumes serial pins sampled on the 10 MHz master clock, serial clock well below it
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module ddstc_core
    import ddstc_pkg::*;
#(
    parameter int ACC_WIDTH = ddstc_pkg::ACC_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic dspReset,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic frame_sync_n,
    input wire logic freq_reg_choice_pin,
    input wire logic phase_reg_choice_pin,
    input wire logic dac_powerdown_pin,
    input wire logic comparatorIn,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [1:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    output logic logicOut,
    output logic logicOutOe,
    output logic dacPowerDown,
    output logic [ddstc_pkg::PH_W-1:0] sinePhase,
    output logic [ddstc_pkg::ACC_W-1:0] accPhase,
    output logic wordDone
);
    import ddstc_pkg::*;

    logic sclkS, sdataS, fsyncS, fpinS, ppinS, sleepS, rstPinS;
    logic sclkPrev_q;
    logic fsyncPrev_q;
    logic [WORD_W-1:0] shift_q;
    logic [BITCNT_W-1:0] bitCnt_q;
    logic active_q;
    logic wordDone_q;
    logic [WORD_W-1:0] control_q;
    logic [ACC_W-1:0] tuning_word_a;
    logic [ACC_W-1:0] tuning_word_b;
    logic [PH_W-1:0] phase_offset_a;
    logic [PH_W-1:0] phase_offset_b;
    logic [ACC_W-1:0] acc_q;
    logic [PH_W-1:0] phase_q;
    logic logicOut_q;
    logic [15:0] rdata_q;
    logic sclkFall, fsyncFall;
    logic [WORD_W-1:0] wordIn;
    logic freq_reg_choice_bit, phaseChoiceBit, pinSwitch;
    logic freqSel, phaseSel;
    logic logic_out_enable, logic_out_source, dac_powerdown_bit;
    logic [ACC_W-1:0] incr;
    logic [PH_W-1:0] offset;
    logic loadWord;
    logic [WORD_W-1:0] loadData;

    ddstc_sync2 u_sclk (.clk(clk), .rst(rst), .pinIn(serial_clk), .pinSync(sclkS));
    ddstc_sync2 u_sdat (.clk(clk), .rst(rst), .pinIn(serial_data_in), .pinSync(sdataS));
    ddstc_sync2 u_fsyn (.clk(clk), .rst(rst), .pinIn(frame_sync_n), .pinSync(fsyncS));
    ddstc_sync2 u_freq_reg_choice_bit (.clk(clk), .rst(rst), .pinIn(freq_reg_choice_pin), .pinSync(fpinS));
    ddstc_sync2 u_psel (.clk(clk), .rst(rst), .pinIn(phase_reg_choice_pin), .pinSync(ppinS));
    ddstc_sync2 u_slp (.clk(clk), .rst(rst), .pinIn(dac_powerdown_pin), .pinSync(sleepS));
    ddstc_sync2 u_drst (.clk(clk), .rst(rst), .pinIn(dspReset), .pinSync(rstPinS));

    // edge detection on synchronised pins
    always_ff @(posedge clk) begin
        if (rst) begin
            // idle low after reset so the synchroniser's own 0 to 1 settling is no falling edge
            sclkPrev_q <= 1'b0;
            fsyncPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= sclkS;
            fsyncPrev_q <= fsyncS;
        end
    end

    assign sclkFall = sclkPrev_q & ~sclkS;
    assign fsyncFall = fsyncPrev_q & ~fsyncS;
    assign wordIn = {shift_q[WORD_W-2:0], sdataS};

    // serial shifter
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= '0;
            bitCnt_q <= '0;
            active_q <= 1'b0;
            wordDone_q <= 1'b0;
        end else begin
            wordDone_q <= 1'b0;
            if (fsyncFall) begin
                active_q <= 1'b1;
                bitCnt_q <= '0;
                if (sclkFall) begin
                    shift_q <= wordIn;
                    bitCnt_q <= 5'h01;
                end
            end else if (fsyncS) begin
                active_q <= 1'b0;
            end else if (active_q && sclkFall) begin
                shift_q <= wordIn;
                bitCnt_q <= bitCnt_q + 5'h01;
                if (bitCnt_q == WORD_BITS - 5'h01) begin
                    active_q <= 1'b0;
                    wordDone_q <= 1'b1;
                end
            end
        end
    end

    assign loadWord = wordDone_q | regWr;
    assign loadData = regWr ? regWdata : shift_q;

    // addressable registers; untouched by dspReset
    always_ff @(posedge clk) begin
        if (rst) begin
            control_q <= CTRL_RST;
            tuning_word_a <= FREQ_RST;
            tuning_word_b <= FREQ_RST;
            phase_offset_a <= PHASE_RST;
            phase_offset_b <= PHASE_RST;
        end else if (loadWord) begin
            unique case (loadData[ADDR_HI:ADDR_LO])
                ADDR_CTRL: begin
                    control_q <= loadData;
                end
                ADDR_FREQ_A: begin
                    if (control_q[CTL_HALF_HI]) begin
                        tuning_word_a[ACC_W-1:HALF_W] <= loadData[HALF_W-1:0];
                    end else begin
                        tuning_word_a[HALF_W-1:0] <= loadData[HALF_W-1:0];
                    end
                end
                ADDR_FREQ_B: begin
                    if (control_q[CTL_HALF_HI]) begin
                        tuning_word_b[ACC_W-1:HALF_W] <= loadData[HALF_W-1:0];
                    end else begin
                        tuning_word_b[HALF_W-1:0] <= loadData[HALF_W-1:0];
                    end
                end
                ADDR_PHASE: begin
                    if (loadData[PH_SEL_BIT]) begin
                        phase_offset_b <= loadData[PH_W-1:0];
                    end else begin
                        phase_offset_a <= loadData[PH_W-1:0];
                    end
                end
            endcase
        end
    end

    assign freq_reg_choice_bit = control_q[CTL_FREQ_REG_CHOICE_BIT];
    assign phaseChoiceBit = control_q[CTL_PSEL];
    assign pinSwitch = control_q[CTL_PINSW];
    assign logic_out_enable = control_q[CTL_OUTEN];
    assign logic_out_source = control_q[CTL_SRC];
    assign dac_powerdown_bit = control_q[CTL_DACPD];
    assign freqSel = pinSwitch ? fpinS : freq_reg_choice_bit;
    assign phaseSel = pinSwitch ? ppinS : phaseChoiceBit;
    assign incr = freqSel ? tuning_word_b : tuning_word_a;
    assign offset = phaseSel ? phase_offset_b : phase_offset_a;

    // phase accumulator: modulo 2^28, f = incr * fclk / 2^28
    always_ff @(posedge clk) begin
        if (rst || rstPinS) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_q + incr;
        end
    end

    // phase offset added to accumulator msbs, truncated to lookup width
    always_ff @(posedge clk) begin
        if (rst || rstPinS) begin
            phase_q <= '0;
        end else begin
            phase_q <= acc_q[ACC_W-1 -: PH_W] + offset;
        end
    end

    // logic output pin
    always_ff @(posedge clk) begin
        if (rst) begin
            logicOut_q <= 1'b0;
        end else begin
            logicOut_q <= logic_out_source ? comparatorIn : phase_q[PH_W-1];
        end
    end

    // register read port
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                ADDR_CTRL: rdata_q <= control_q;
                ADDR_FREQ_A: rdata_q <= {2'h0, acc_q[ACC_W-1:HALF_W]};
                ADDR_FREQ_B: rdata_q <= {4'h0, phase_q};
                ADDR_PHASE: rdata_q <= {13'h0000, freqSel, phaseSel, dacPowerDown};
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign regRdata = rdata_q;
    assign logicOut = logicOut_q;
    assign logicOutOe = logic_out_enable;
    assign dacPowerDown = sleepS | dac_powerdown_bit;
    assign sinePhase = phase_q;
    assign accPhase = acc_q;
    assign wordDone = wordDone_q;

    chk_acc_step: assert property (@(posedge clk) disable iff (rst)
        !rstPinS |=> acc_q == $past(acc_q) + $past(incr))
        else $error("accumulator did not add increment");
    chk_reset_clear: assert property (@(posedge clk) disable iff (rst)
        rstPinS |=> acc_q == '0 && phase_q == '0)
        else $error("reset did not clear datapath");
    chk_reset_keep: assert property (@(posedge clk) disable iff (rst)
        rstPinS && !loadWord |=> $stable(control_q) && $stable(tuning_word_a))
        else $error("reset altered registers");
    chk_phase_sum: assert property (@(posedge clk) disable iff (rst)
        !rstPinS |=> phase_q == $past(acc_q[ACC_W-1 -: PH_W]) + $past(offset))
        else $error("phase sum wrong");
    chk_freq_pick: assert property (@(posedge clk) disable iff (rst)
        pinSwitch |-> incr == (fpinS ? tuning_word_b : tuning_word_a))
        else $error("frequency select wrong");
    chk_phase_pick: assert property (@(posedge clk) disable iff (rst)
        !pinSwitch |-> offset == (phaseChoiceBit ? phase_offset_b : phase_offset_a))
        else $error("phase select wrong");
    chk_pd_equiv: assert property (@(posedge clk) disable iff (rst)
        (sleepS || dac_powerdown_bit) |-> dacPowerDown)
        else $error("power-down not applied");
    chk_out_enable: assert property (@(posedge clk) disable iff (rst)
        logicOutOe == control_q[CTL_OUTEN])
        else $error("output enable mismatch");
    chk_word_len: assert property (@(posedge clk) disable iff (rst)
        wordDone_q |-> $past(bitCnt_q) == WORD_BITS - 5'h01)
        else $error("word length not sixteen");
    chk_sync_start: assert property (@(posedge clk) disable iff (rst)
        fsyncFall && !sclkFall |=> active_q && bitCnt_q == '0)
        else $error("sync did not start word");
    cov_word: cover property (@(posedge clk) wordDone_q);
    cov_reset: cover property (@(posedge clk) rstPinS ##1 !rstPinS);
    cov_pinsw: cover property (@(posedge clk) pinSwitch && $changed(fpinS));
    cov_bitsel: cover property (@(posedge clk) !pinSwitch && freq_reg_choice_bit && phaseChoiceBit);
    cov_pdpin: cover property (@(posedge clk) sleepS ##1 !sleepS);

    // logic output source
    chk_out_phase: assert property (@(posedge clk) disable iff (rst)
        !logic_out_source |=> logicOut_q == $past(phase_q[PH_W-1]))
        else $error("logic output not phase msb");
    chk_out_cmp: assert property (@(posedge clk) disable iff (rst)
        logic_out_source |=> logicOut_q == $past(comparatorIn))
        else $error("logic output not comparator");

    // register read port
    chk_rd_idle: assert property (@(posedge clk) disable iff (rst)
        !regRd |=> rdata_q == '0)
        else $error("read data not zero when idle");
    chk_rd_ctrl: assert property (@(posedge clk) disable iff (rst)
        regRd && regAddr == ADDR_CTRL |=> rdata_q == $past(control_q))
        else $error("control read wrong");

    // power-down
    chk_pd_off: assert property (@(posedge clk) disable iff (rst)
        !sleepS && !dac_powerdown_bit |-> !dacPowerDown)
        else $error("power-down without cause");

    // device reset keeps the other registers
    chk_keep_rest: assert property (@(posedge clk) disable iff (rst)
        rstPinS && !loadWord |=> $stable(tuning_word_b) && $stable(phase_offset_a)
            && $stable(phase_offset_b))
        else $error("reset altered offsets");

    // word loading
    chk_word_load: assert property (@(posedge clk) disable iff (rst)
        wordDone_q && !regWr && shift_q[ADDR_HI:ADDR_LO] == ADDR_CTRL
            |=> control_q == $past(shift_q))
        else $error("serial word not applied");
    chk_port_load: assert property (@(posedge clk) disable iff (rst)
        regWr && regWdata[ADDR_HI:ADDR_LO] == ADDR_CTRL |=> control_q == $past(regWdata))
        else $error("port write not applied");
    chk_shift_bit: assert property (@(posedge clk) disable iff (rst)
        active_q && sclkFall && !fsyncFall && !fsyncS |=> shift_q[0] == $past(sdataS))
        else $error("serial bit not shifted in");
    chk_frame_idle: assert property (@(posedge clk) disable iff (rst)
        fsyncS && !fsyncFall |=> !active_q)
        else $error("word active outside frame");

    // select paths not covered above
    chk_phase_pin: assert property (@(posedge clk) disable iff (rst)
        pinSwitch |-> offset == (ppinS ? phase_offset_b : phase_offset_a))
        else $error("phase pin select wrong");
    chk_freq_bit: assert property (@(posedge clk) disable iff (rst)
        !pinSwitch |-> incr == (freq_reg_choice_bit ? tuning_word_b : tuning_word_a))
        else $error("frequency bit select wrong");
endmodule

// ---- verif/ddstc_host_model.sv ----
// host model: drives one 16-bit word on the 3-wire serial port per send call
// assumes the core samples the serial pins on its own master clock
`timescale 1ns/1ps
module ddstc_host_model (
    output logic serialClk,
    output logic serialData,
    output logic frameSyncN
);
    initial begin
        serialClk = 1'b1;
        serialData = 1'b0;
        frameSyncN = 1'b1;
    end
    task automatic send(input logic [15:0] w);
        int i;
        frameSyncN = 1'b0;
        #400;
        for (i = 15; i >= 0; i--) begin
            serialData = w[i];
            #400;
            serialClk = 1'b0;
            #400;
            serialClk = 1'b1;
        end
        frameSyncN = 1'b1;
        serialData = ~serialData;
    endtask
endmodule

// ---- verif/ddstc_core_tb_top.sv ----
// bench for ddstc_core: model of registers and datapath compared at the check points of each dp and rd call
// assumes ddstc_host_model drives the serial pins and the core clock is 10 MHz
`timescale 1ns/1ps
module ddstc_core_tb_top;
    import ddstc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dspReset = 1'b0, fPin = 1'b0, pPin = 1'b0, pdPin = 1'b0, cmpIn = 1'b0;
    logic regWr = 1'b0, regRd = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [15:0] regWdata = 16'h0000, regRdata, ctrl = 16'h0000, rnd = 16'h1992;
    logic logicOut, logicOutOe, dacPowerDown, wordDone, sClk, sDat, sFs;
    logic [PH_W-1:0] sinePhase, offA = 12'h000, offB = 12'h000;
    logic [ACC_W-1:0] accPhase, tA = 28'h0, tB = 28'h0;
    logic [15:0] modes [5] = '{16'h0020, 16'h0430, 16'h0220, 16'h0630, 16'h0000};
    int err_count = 0, n_compared = 0, cyc = 0, doneCnt = 0;
    always #50 clk = ~clk;
    ddstc_host_model i_host (.serialClk(sClk), .serialData(sDat), .frameSyncN(sFs));
    ddstc_core i_dut (.clk(clk), .rst(rst), .dspReset(dspReset), .serial_clk(sClk),
        .serial_data_in(sDat), .frame_sync_n(sFs), .freq_reg_choice_pin(fPin),
        .phase_reg_choice_pin(pPin), .dac_powerdown_pin(pdPin), .comparatorIn(cmpIn),
        .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .logicOut(logicOut), .logicOutOe(logicOutOe),
        .dacPowerDown(dacPowerDown), .sinePhase(sinePhase), .accPhase(accPhase),
        .wordDone(wordDone));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [27:0] e, input logic [27:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    always @(posedge clk) begin
        cyc++;
        if (wordDone === 1'b1)
            doneCnt++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic model(input logic [15:0] w);
        case (w[15:14])
            2'h0: ctrl = w;
            2'h1: if (ctrl[11]) tA[27:14] = w[13:0]; else tA[13:0] = w[13:0];
            2'h2: if (ctrl[11]) tB[27:14] = w[13:0]; else tB[13:0] = w[13:0];
            default: if (w[12]) offB = w[11:0]; else offA = w[11:0];
        endcase
    endtask
    task automatic wr(input logic [15:0] w);
        @(posedge clk);
        regWr <= 1'b1;
        regWdata <= w;
        @(posedge clk);
        regWr <= 1'b0;
        model(w);
        repeat (3) @(posedge clk);
    endtask
    task automatic sw(input logic [15:0] w);
        int d;
        d = doneCnt;
        i_host.send(w);
        repeat (20) @(posedge clk);
        chk("words done", d + 1, doneCnt);
        model(w);
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] e, input string n);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(n, e, regRdata);
    endtask
    task automatic dp(input string n);
        logic [27:0] a0, inc;
        logic [11:0] off;
        repeat (6) @(negedge clk);
        inc = (ctrl[8] ? fPin : ctrl[10]) ? tB : tA;
        off = (ctrl[8] ? pPin : ctrl[9]) ? offB : offA;
        a0 = accPhase;
        @(negedge clk);
        chk({n, " acc"}, a0 + inc, accPhase);
        chk({n, " phase"}, 12'(a0[27:16] + off), sinePhase);
        a0 = sinePhase;
        @(negedge clk);
        chk({n, " out"}, ctrl[4] ? cmpIn : a0[11], logicOut);
        chk({n, " oe"}, ctrl[5], logicOutOe);
        $display("test %s done", n);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(2'h0, 16'h0000, "ctrl reset");
        dp("reset");
        sw(16'h4000 | rnd[13:0]);
        rnd = lfsr(rnd);
        wr(16'h8000 | rnd[13:0]);
        wr(16'h0800);
        rnd = lfsr(rnd);
        sw(16'h4000 | rnd[13:0]);
        rnd = lfsr(rnd);
        sw(16'hc000 | rnd[11:0]);
        rnd = lfsr(rnd);
        wr(16'hd000 | rnd[11:0]);
        cmpIn <= 1'b1;
        foreach (modes[i]) begin
            wr(modes[i]);
            dp("bit select");
        end
        fPin <= 1'b1;
        pPin <= 1'b1;
        wr(16'h0120);
        dp("pin select");
        fPin <= 1'b0;
        dp("pin switch");
        pdPin <= 1'b1;
        repeat (5) @(negedge clk);
        chk("pd pin", 1'b1, dacPowerDown);
        @(posedge clk);
        pdPin <= 1'b0;
        wr(16'h0040);
        @(negedge clk);
        chk("pd bit", 1'b1, dacPowerDown);
        wr(16'h0020);
        @(negedge clk);
        chk("pd off", 1'b0, dacPowerDown);
        @(posedge clk);
        dspReset <= 1'b1;
        repeat (6) @(negedge clk);
        chk("dsp acc", 28'h0, accPhase);
        chk("dsp phase", 12'h000, sinePhase);
        @(posedge clk);
        dspReset <= 1'b0;
        rd(2'h0, ctrl, "ctrl kept");
        dp("after dsp");
        end_sim();
    end
endmodule
